// ### design/cbr_cfg_regs.sv
`timescale 1ns/100ps
`include "cbr_defines.svh"
module cbr_cfg_regs
  import cbr_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic HOST_BUS_RESET_IN,
  input wire logic CFG_FUNC,
  input wire logic [7:2] CFG_ADDR,
  input wire logic [3:0] CFG_BYTE_EN,
  input wire logic CFG_WRITE,
  input wire logic CFG_READ,
  input wire logic [31:0] CFG_WDATA,
  output logic [31:0] CFG_RDATA,
  output logic CFG_DONE,
  input wire logic IRQ_MERGE_ALL,
  input wire logic IRQ_PAIR_TIE,
  input wire logic SUBSYSTEM_WRITE_LOCK,
  input wire logic POWER_MGMT_EVENT_EN,
  input wire logic SERR_ENABLE,
  input wire logic EEPROM_LOAD,
  input wire logic [15:0] EEPROM_MAKER_CODE,
  input wire logic [15:0] EEPROM_PRODUCT_CODE,
  input wire logic CARD_SYSTEM_ERROR,
  input wire logic CARD_PARITY_DETECTED,
  input wire logic CARD_MASTER_ABORT,
  input wire logic CARD_FUNC_IRQ,
  input wire logic FWD_REQ,
  input wire logic FWD_IS_IO,
  input wire logic [31:0] FWD_ADDR,
  output logic CARD_RESET_OUT,
  output logic BURST_WRITE_POSTING_ON,
  output logic MEM_WINDOW1_PREFETCHABLE,
  output logic MEM_WINDOW0_PREFETCHABLE,
  output logic CARD_IRQ_ROUTE_SELECT,
  output logic HOST_TARGET_ABORT,
  output logic HOST_SERR,
  output logic CARD_PARITY_ERROR,
  output logic IRQ_TO_PCI,
  output logic IRQ_TO_LEGACY,
  output logic FWD_VGA_HIT,
  output logic FWD_ISA_BLOCK
);
  typedef struct packed {
    logic [7:0] line_card;
    logic [7:0] line_serial;
    cbr_bridge_t bridge;
    logic [15:0] maker;
    logic [15:0] product;
    logic [31:0] rdata;
    logic done;
    logic card_reset;
  } cbr_state_t;

  cbr_state_t st;
  cbr_state_t next_st;
  logic [1:0] pin_level;
  logic host_rst;
  logic card_syserr;
  logic hit_line;
  logic hit_subsys;
  logic [7:0] pin_now;
  logic [15:0] bridge_wr;
  cbr_fwd_if fif();

  // Pins from outside the clock domain
  cbr_pin_sync u_sync (
    .clk(CLOCK),
    .rst(RESET),
    .pin({CARD_SYSTEM_ERROR, HOST_BUS_RESET_IN}),
    .level(pin_level)
  );

  assign host_rst = pin_level[0];
  assign card_syserr = pin_level[1];

  // Control and event paths towards the forwarding logic
  assign fif.ctl = st.bridge;
  assign fif.serr_en = SERR_ENABLE;
  assign fif.card_abort = CARD_MASTER_ABORT;
  assign fif.card_syserr = card_syserr;
  assign fif.parity_det = CARD_PARITY_DETECTED;
  assign fif.func_irq = CARD_FUNC_IRQ;
  assign fif.req = FWD_REQ;
  assign fif.is_io = FWD_IS_IO;
  assign fif.addr = FWD_ADDR;

  cbr_forward u_fwd (
    .clk(CLOCK),
    .rst(RESET),
    .f(fif.fwd)
  );

  // Address decode and pin byte
  always_comb begin
    hit_line = (CFG_ADDR == 6'(`CBR_OFS_IRQ_LINE >> 2));
    hit_subsys = (CFG_ADDR == 6'(`CBR_OFS_SUBSYS_MAKER >> 2));
    pin_now = cbr_pin_value(CFG_FUNC, IRQ_MERGE_ALL);
    bridge_wr = cbr_merge16(st.bridge, CFG_WDATA[31:16], CFG_BYTE_EN[3:2]);
  end

  // Register update, read answer and card reset
  always_comb begin
    next_st = st;
    next_st.done = CFG_READ || CFG_WRITE;
    // Host reset restores context bits to their reset values, card reset bit kept, unless power events are enabled
    if (host_rst && !POWER_MGMT_EVENT_EN) begin
      next_st.bridge = `CBR_RST_BRIDGE;
      next_st.bridge.card_reset_ctl = st.bridge.card_reset_ctl;
    end else if (CFG_WRITE && hit_line) begin
      if (CFG_FUNC == `CBR_FUNC_CARD) begin
        if (CFG_BYTE_EN[0]) begin
          next_st.line_card = CFG_WDATA[7:0];
        end
        next_st.bridge = (bridge_wr & `CBR_BRIDGE_WMASK) |
          (st.bridge & ~`CBR_BRIDGE_WMASK);
      end else if (CFG_BYTE_EN[0]) begin
        next_st.line_serial = CFG_WDATA[7:0];
      end
      // Pin byte lane is never stored
    end
    // Serial memory load takes priority over software writes
    if (EEPROM_LOAD) begin
      next_st.maker = EEPROM_MAKER_CODE;
      next_st.product = EEPROM_PRODUCT_CODE;
    end else if (CFG_WRITE && hit_subsys && !SUBSYSTEM_WRITE_LOCK &&
        CFG_FUNC == `CBR_FUNC_CARD) begin
      next_st.maker = cbr_merge16(st.maker, CFG_WDATA[15:0],
        CFG_BYTE_EN[1:0]);
      next_st.product = cbr_merge16(st.product, CFG_WDATA[31:16],
        CFG_BYTE_EN[3:2]);
    end
    if (CFG_READ) begin
      next_st.rdata = 32'h0000_0000;
      if (hit_line && CFG_FUNC == `CBR_FUNC_CARD) begin
        next_st.rdata = {st.bridge, pin_now, st.line_card};
      end else if (hit_line) begin
        next_st.rdata = {16'h0000, pin_now, st.line_serial};
      end else if (hit_subsys && CFG_FUNC == `CBR_FUNC_CARD) begin
        next_st.rdata = {st.product, st.maker};
      end
    end
    next_st.card_reset = next_st.bridge.card_reset_ctl || host_rst;
  end

  // Global reset returns every register to its reset value
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      st.line_card <= `CBR_RST_IRQ_LINE;
      st.line_serial <= `CBR_RST_IRQ_LINE;
      st.bridge <= `CBR_RST_BRIDGE;
      st.maker <= `CBR_RST_SUBSYS;
      st.product <= `CBR_RST_SUBSYS;
      st.rdata <= 32'h0000_0000;
      st.done <= 1'b0;
      st.card_reset <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign CFG_RDATA = st.rdata;
  assign CFG_DONE = st.done;
  assign CARD_RESET_OUT = st.card_reset;
  assign BURST_WRITE_POSTING_ON = st.bridge.burst_write_posting_on;
  assign MEM_WINDOW1_PREFETCHABLE = st.bridge.mem_window1_prefetchable;
  assign MEM_WINDOW0_PREFETCHABLE = st.bridge.mem_window0_prefetchable;
  assign CARD_IRQ_ROUTE_SELECT = st.bridge.card_irq_route_select;
  assign HOST_TARGET_ABORT = fif.target_abort;
  assign HOST_SERR = fif.serr;
  assign CARD_PARITY_ERROR = fif.parity_err;
  assign IRQ_TO_PCI = fif.irq_pci;
  assign IRQ_TO_LEGACY = fif.irq_legacy;
  assign FWD_VGA_HIT = fif.vga_hit;
  assign FWD_ISA_BLOCK = fif.isa_block;

  sequence s_line_read;
    CFG_READ && hit_line;
  endsequence

  sequence s_card_line_write;
    CFG_WRITE && hit_line && CFG_FUNC == `CBR_FUNC_CARD &&
      !(host_rst && !POWER_MGMT_EVENT_EN);
  endsequence

  property p_line_reset;
    @(posedge CLOCK) RESET |=> st.line_card == 8'hff;
  endproperty
  a_line_reset: assert property (p_line_reset)
    else $error("interrupt line byte not all ones after reset");

  property p_pin_read;
    @(posedge CLOCK) disable iff (RESET)
    s_line_read |=> CFG_DONE && CFG_RDATA[15:8] ==
      (($past(CFG_FUNC) && !$past(IRQ_MERGE_ALL)) ? 8'h03 : 8'h01);
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("interrupt pin byte wrong");

  property p_reserved_zero;
    @(posedge CLOCK) disable iff (RESET)
    st.bridge.reserved_hi == 5'h00 && !st.bridge.reserved_bits;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bridge control bit set");

  property p_card_reset;
    @(posedge CLOCK) disable iff (RESET)
    host_rst |=> CARD_RESET_OUT;
  endproperty
  a_card_reset: assert property (p_card_reset)
    else $error("card reset not driven");

  property p_card_reset_bit;
    @(posedge CLOCK) disable iff (RESET)
    st.bridge.card_reset_ctl |-> CARD_RESET_OUT;
  endproperty
  a_card_reset_bit: assert property (p_card_reset_bit)
    else $error("card reset output does not follow its control bit");

  property p_pair_tie_kept;
    @(posedge CLOCK) disable iff (RESET)
    s_line_read ##0 (CFG_FUNC == `CBR_FUNC_SERIAL && IRQ_PAIR_TIE &&
      !IRQ_MERGE_ALL) |=> CFG_RDATA[15:8] == `CBR_PIN_THIRD;
  endproperty
  a_pair_tie_kept: assert property (p_pair_tie_kept)
    else $error("pair tie changed the serial function pin byte");

  property p_line_write;
    @(posedge CLOCK) disable iff (RESET)
    s_card_line_write ##0 CFG_BYTE_EN[0] |=>
      st.line_card == $past(CFG_WDATA[7:0]);
  endproperty
  a_line_write: assert property (p_line_write)
    else $error("interrupt line byte write lost");

  property p_posting_write;
    @(posedge CLOCK) disable iff (RESET)
    s_card_line_write ##0 CFG_BYTE_EN[3] |=>
      BURST_WRITE_POSTING_ON == $past(CFG_WDATA[26]);
  endproperty
  a_posting_write: assert property (p_posting_write)
    else $error("write posting control not taken from its bit");

  property p_ctx_clear;
    @(posedge CLOCK) disable iff (RESET)
    host_rst && !POWER_MGMT_EVENT_EN |=>
      (st.bridge | 16'h0040) == (`CBR_RST_BRIDGE | 16'h0040);
  endproperty
  a_ctx_clear: assert property (p_ctx_clear)
    else $error("host reset left context bits set");

  property p_subsys_write;
    @(posedge CLOCK) disable iff (RESET)
    CFG_WRITE && hit_subsys && !SUBSYSTEM_WRITE_LOCK && !EEPROM_LOAD &&
      CFG_FUNC == `CBR_FUNC_CARD && CFG_BYTE_EN[0] && CFG_BYTE_EN[1] |=>
      st.maker == $past(CFG_WDATA[15:0]);
  endproperty
  a_subsys_write: assert property (p_subsys_write)
    else $error("unlocked subsystem maker code not written");

  property p_host_rst_keep;
    @(posedge CLOCK) disable iff (RESET)
    host_rst && !CFG_WRITE |=> $stable(st.bridge.card_reset_ctl);
  endproperty
  a_host_rst_keep: assert property (p_host_rst_keep)
    else $error("host reset altered card reset control");

  property p_pme_keep;
    @(posedge CLOCK) disable iff (RESET)
    host_rst && POWER_MGMT_EVENT_EN && !CFG_WRITE |=> $stable(st.bridge);
  endproperty
  a_pme_keep: assert property (p_pme_keep)
    else $error("context bits cleared while power events enabled");

  property p_subsys_lock;
    @(posedge CLOCK) disable iff (RESET)
    CFG_WRITE && hit_subsys && SUBSYSTEM_WRITE_LOCK && !EEPROM_LOAD |=>
      $stable(st.maker) && $stable(st.product);
  endproperty
  a_subsys_lock: assert property (p_subsys_lock)
    else $error("locked subsystem code changed");

  property p_eeprom_load;
    @(posedge CLOCK) disable iff (RESET)
    EEPROM_LOAD |=> st.maker == $past(EEPROM_MAKER_CODE) &&
      st.product == $past(EEPROM_PRODUCT_CODE);
  endproperty
  a_eeprom_load: assert property (p_eeprom_load)
    else $error("subsystem codes not loaded");
endmodule

// ### design/cbr_forward.sv
`timescale 1ns/100ps
module cbr_forward
  import cbr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  cbr_fwd_if.fwd f
);
  typedef struct packed {
    logic target_abort;
    logic serr;
    logic parity_err;
    logic irq_pci;
    logic irq_legacy;
    logic vga_hit;
    logic isa_block;
  } cbr_fwd_t;

  cbr_fwd_t st;
  cbr_fwd_t next_st;
  logic low_io;
  logic vga_io;
  logic vga_mem;

  // Address classes
  always_comb begin
    low_io = f.is_io && (f.addr[31:16] == 16'h0000);
    vga_io = low_io && ((f.addr[15:0] >= 16'h03b0 &&
      f.addr[15:0] <= 16'h03bb) || (f.addr[15:0] >= 16'h03c0 &&
      f.addr[15:0] <= 16'h03df));
    vga_mem = !f.is_io && (f.addr[31:17] == 15'h0005);
  end

  // Error, interrupt and decode results
  always_comb begin
    next_st = st;
    next_st.target_abort = f.card_abort && f.ctl.master_abort_report_mode;
    next_st.serr = f.serr_en && ((f.card_abort &&
      f.ctl.master_abort_report_mode) ||
      (f.card_syserr && f.ctl.card_syserr_forward_on));
    next_st.parity_err = f.parity_det && f.ctl.card_parity_report_on;
    next_st.irq_pci = f.func_irq && !f.ctl.card_irq_route_select;
    next_st.irq_legacy = f.func_irq && f.ctl.card_irq_route_select;
    if (f.req) begin
      next_st.vga_hit = (vga_io || vga_mem) && f.ctl.vga_forward_on;
      next_st.isa_block = low_io && (f.addr[9:8] != 2'b00) &&
        f.ctl.isa_alias_filter_on;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign f.target_abort = st.target_abort;
  assign f.serr = st.serr;
  assign f.parity_err = st.parity_err;
  assign f.irq_pci = st.irq_pci;
  assign f.irq_legacy = st.irq_legacy;
  assign f.vga_hit = st.vga_hit;
  assign f.isa_block = st.isa_block;

  property p_abort_ignored;
    @(posedge clk) disable iff (rst)
    !f.ctl.master_abort_report_mode |=> !st.target_abort;
  endproperty
  a_abort_ignored: assert property (p_abort_ignored)
    else $error("master abort reported while reporting is off");

  property p_syserr_fwd;
    @(posedge clk) disable iff (rst)
    f.card_syserr && f.serr_en && f.ctl.card_syserr_forward_on |=> st.serr;
  endproperty
  a_syserr_fwd: assert property (p_syserr_fwd)
    else $error("card system error not forwarded");

  property p_isa_block;
    @(posedge clk) disable iff (rst)
    f.req && f.ctl.isa_alias_filter_on && f.is_io &&
      f.addr[31:16] == 16'h0000 && f.addr[9:8] == 2'b11 |=> st.isa_block;
  endproperty
  a_isa_block: assert property (p_isa_block)
    else $error("alias I/O cycle not blocked");
endmodule

// ### design/cbr_pin_sync.sv
`timescale 1ns/100ps
module cbr_pin_sync
  import cbr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] pin,
  output logic [1:0] level
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] level;
  } cbr_sync_t;

  cbr_sync_t st;
  cbr_sync_t next_st;

  // Three stages; a change counts once stages two and three agree
  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < 2; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.level[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;
endmodule

// ### dv/cbr_cfg_regs_bench.sv
`timescale 1ns/100ps
// Register bank bench: config accesses through the host model, side pins
module cbr_cfg_regs_bench;
  logic clock, reset, host_rst, merge_all, pair_tie, wr_lock, pme_en;
  logic serr_en, ee_load, sys_err, par_det, m_abort, func_irq;
  logic fwd_req, fwd_io;
  logic [15:0] ee_maker, ee_product;
  logic [31:0] fwd_addr, rd, cfg_wdata, cfg_rdata;
  logic cfg_func, cfg_write, cfg_read, cfg_done;
  logic [7:2] cfg_addr;
  logic [3:0] cfg_be;
  logic card_rst, posting, pf1, pf0, route, t_abort, serr, par_err;
  logic irq_pci, irq_leg, vga_hit, isa_blk;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  cbr_host_model i_cbr_host_model (.CLOCK(clock), .CFG_FUNC(cfg_func),
    .CFG_ADDR(cfg_addr), .CFG_BYTE_EN(cfg_be), .CFG_WRITE(cfg_write),
    .CFG_READ(cfg_read), .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata),
    .CFG_DONE(cfg_done));

  cbr_cfg_regs i_cbr_cfg_regs (.CLOCK(clock), .RESET(reset),
    .HOST_BUS_RESET_IN(host_rst), .CFG_FUNC(cfg_func), .CFG_ADDR(cfg_addr),
    .CFG_BYTE_EN(cfg_be), .CFG_WRITE(cfg_write), .CFG_READ(cfg_read),
    .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata), .CFG_DONE(cfg_done),
    .IRQ_MERGE_ALL(merge_all), .IRQ_PAIR_TIE(pair_tie),
    .SUBSYSTEM_WRITE_LOCK(wr_lock), .POWER_MGMT_EVENT_EN(pme_en),
    .SERR_ENABLE(serr_en), .EEPROM_LOAD(ee_load),
    .EEPROM_MAKER_CODE(ee_maker), .EEPROM_PRODUCT_CODE(ee_product),
    .CARD_SYSTEM_ERROR(sys_err), .CARD_PARITY_DETECTED(par_det),
    .CARD_MASTER_ABORT(m_abort), .CARD_FUNC_IRQ(func_irq),
    .FWD_REQ(fwd_req), .FWD_IS_IO(fwd_io), .FWD_ADDR(fwd_addr),
    .CARD_RESET_OUT(card_rst), .BURST_WRITE_POSTING_ON(posting),
    .MEM_WINDOW1_PREFETCHABLE(pf1), .MEM_WINDOW0_PREFETCHABLE(pf0),
    .CARD_IRQ_ROUTE_SELECT(route), .HOST_TARGET_ABORT(t_abort),
    .HOST_SERR(serr), .CARD_PARITY_ERROR(par_err), .IRQ_TO_PCI(irq_pci),
    .IRQ_TO_LEGACY(irq_leg), .FWD_VGA_HIT(vga_hit),
    .FWD_ISA_BLOCK(isa_blk));

  // Clock at 4 ns period
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic f, input logic [7:2] a, input logic [3:0] be,
      input logic [31:0] d);
    i_cbr_host_model.xfer(1'b1, f, a, be, d, rd);
  endtask

  task automatic rd_chk(input logic f, input logic [7:2] a,
      input logic [31:0] e);
    i_cbr_host_model.xfer(1'b0, f, a, 4'hf, 32'h0, rd);
    chk(rd, e);
  endtask

  // Decode request pulse, result compared one cycle later
  task automatic fwd(input logic io, input logic [31:0] a,
      input logic [1:0] e);
    fwd_io = io;
    fwd_addr = a;
    fwd_req = 1'b1;
    tick(1);
    fwd_req = 1'b0;
    chk(32'({vga_hit, isa_blk}), 32'(e));
    tick(1);
  endtask

  // Main sequence
  initial begin
    {reset, wr_lock} = 2'b11;
    {host_rst, merge_all, pair_tie, pme_en, serr_en, ee_load} = 6'h00;
    {sys_err, par_det, m_abort, func_irq, fwd_req, fwd_io} = 6'h00;
    {ee_maker, ee_product, fwd_addr} = 64'h0;
    repeat (10) @(posedge clock);
    #1;
    reset = 1'b0;
    chk(32'({card_rst, pf1, pf0, route, posting}), 32'h1c);
    rd_chk(1'b0, 6'h0f, 32'h0340_01ff);
    rd_chk(1'b0, 6'h10, 32'h0000_0000);
    wr(1'b0, 6'h11, 4'hf, 32'hffff_ffff);
    rd_chk(1'b0, 6'h11, 32'h0000_0000);
    // Pin byte for every tie setting, both functions
    for (int k = 0; k < 4; k++) begin
      {pair_tie, merge_all} = 2'(k);
      rd_chk(1'b1, 6'h0f, {16'h0, (k[0] ? 8'h01 : 8'h03), 8'hff});
      rd_chk(1'b0, 6'h0f, 32'h0340_01ff);
    end
    // Pin byte and reserved bits ignore writes
    wr(1'b0, 6'h0f, 4'hf, 32'hffff_ff5a);
    rd_chk(1'b0, 6'h0f, 32'h07ef_015a);
    chk(32'({card_rst, pf1, pf0, route, posting}), 32'h1f);
    wr(1'b0, 6'h0f, 4'hc, 32'h0000_0000);
    rd_chk(1'b0, 6'h0f, 32'h0000_015a);
    chk(32'({card_rst, pf1, pf0, route, posting}), 32'h00);
    // Host reset without power events restores all bridge control bits but the card reset bit
    host_rst = 1'b1;
    tick(6);
    chk(32'(card_rst), 32'h1);
    rd_chk(1'b0, 6'h0f, 32'h0300_015a);
    host_rst = 1'b0;
    tick(6);
    chk(32'(card_rst), 32'h0);
    // With power events enabled host reset keeps the bits
    wr(1'b0, 6'h0f, 4'hc, 32'h0023_0000);
    {pme_en, host_rst} = 2'b11;
    tick(6);
    rd_chk(1'b0, 6'h0f, 32'h0023_015a);
    chk(32'(card_rst), 32'h1);
    host_rst = 1'b0;
    tick(6);
    pme_en = 1'b0;
    // Abort, system error and parity with reporting on
    {serr_en, m_abort} = 2'b11;
    tick(1);
    m_abort = 1'b0;
    chk(32'({t_abort, serr}), 32'h3);
    tick(1);
    chk(32'({t_abort, serr}), 32'h0);
    {par_det, sys_err, func_irq} = 3'b111;
    tick(6);
    chk(32'({par_err, serr, irq_pci, irq_leg}), 32'he);
    // Reporting off, interrupts routed to legacy
    wr(1'b0, 6'h0f, 4'hc, 32'h0080_0000);
    m_abort = 1'b1;
    tick(1);
    m_abort = 1'b0;
    chk(32'({t_abort, serr, par_err, irq_pci, irq_leg}), 32'h01);
    {par_det, sys_err, func_irq} = 3'b000;
    // Address decode with forwarding bits on, then off
    wr(1'b0, 6'h0f, 4'hc, 32'h000c_0000);
    fwd(1'b0, 32'h000a_0000, 2'b10);
    fwd(1'b1, 32'h0000_0100, 2'b01);
    fwd(1'b1, 32'h0000_03c0, 2'b11);
    fwd(1'b1, 32'h0000_0000, 2'b00);
    fwd(1'b1, 32'h0001_0100, 2'b00);
    wr(1'b0, 6'h0f, 4'hc, 32'h0000_0000);
    fwd(1'b0, 32'h000a_0000, 2'b00);
    fwd(1'b1, 32'h0000_0300, 2'b00);
    // Subsystem codes: lock, byte lanes, host reset, serial memory load
    wr(1'b0, 6'h10, 4'hf, 32'h5678_1234);
    rd_chk(1'b0, 6'h10, 32'h0000_0000);
    wr_lock = 1'b0;
    wr(1'b0, 6'h10, 4'h3, 32'h5678_1234);
    rd_chk(1'b0, 6'h10, 32'h0000_1234);
    wr(1'b0, 6'h10, 4'hc, 32'h5678_0000);
    wr_lock = 1'b1;
    host_rst = 1'b1;
    tick(6);
    host_rst = 1'b0;
    tick(6);
    rd_chk(1'b0, 6'h10, 32'h5678_1234);
    {ee_maker, ee_product, ee_load} = {16'h9abc, 16'hdef0, 1'b1};
    tick(1);
    ee_load = 1'b0;
    rd_chk(1'b0, 6'h10, 32'hdef0_9abc);
    // Global reset clears codes and sets the card reset bit again
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    rd_chk(1'b0, 6'h10, 32'h0000_0000);
    rd_chk(1'b0, 6'h0f, 32'h0340_01ff);
    report_and_stop();
  end
endmodule

// ### dv/cbr_host_model.sv
`timescale 1ns/100ps
// Host configuration master: one access at a time, answer sampled one cycle after the request
module cbr_host_model (
  input wire logic CLOCK,
  output logic CFG_FUNC,
  output logic [7:2] CFG_ADDR,
  output logic [3:0] CFG_BYTE_EN,
  output logic CFG_WRITE,
  output logic CFG_READ,
  output logic [31:0] CFG_WDATA,
  input wire logic [31:0] CFG_RDATA,
  input wire logic CFG_DONE
);
  // Idle bus at time zero
  initial begin
    CFG_FUNC = 1'b0;
    CFG_ADDR = 6'h00;
    CFG_BYTE_EN = 4'h0;
    CFG_WRITE = 1'b0;
    CFG_READ = 1'b0;
    CFG_WDATA = 32'h0000_0000;
  end

  // One request pulse, answer taken in the cycle that follows
  task automatic xfer(input logic wr, input logic func, input logic [7:2] a,
      input logic [3:0] be, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge CLOCK);
    #1;
    CFG_FUNC = func;
    CFG_ADDR = a;
    CFG_BYTE_EN = be;
    CFG_WDATA = wd;
    CFG_WRITE = wr;
    CFG_READ = !wr;
    @(posedge CLOCK);
    #1;
    CFG_WRITE = 1'b0;
    CFG_READ = 1'b0;
    // Released lines no longer show the old value
    CFG_ADDR = ~a;
    CFG_WDATA = ~wd;
    rd = (CFG_DONE === 1'b1) ? CFG_RDATA : 32'hxxxx_xxxx;
  endtask
endmodule

// ### shared/cbr_defines.svh
`ifndef CBR_DEFINES_SVH
`define CBR_DEFINES_SVH

// Configuration byte offsets of the registers of this block
`define CBR_OFS_IRQ_LINE 8'h3c
`define CBR_OFS_IRQ_PIN 8'h3d
`define CBR_OFS_BRIDGE 8'h3e
`define CBR_OFS_SUBSYS_MAKER 8'h40
`define CBR_OFS_SUBSYS_PRODUCT 8'h42

// Reset values
`define CBR_RST_IRQ_LINE 8'hff
`define CBR_RST_BRIDGE 16'h0340
`define CBR_RST_SUBSYS 16'h0000

// Interrupt pin codes
`define CBR_PIN_FIRST 8'h01
`define CBR_PIN_THIRD 8'h03

// Writable bridge control bits: 10..5 and 3..0
`define CBR_BRIDGE_WMASK 16'h07ef

// Bridge control bit positions
`define CBR_BIT_POSTING 10
`define CBR_BIT_MEM_WINDOW1_PREFETCHABLE 9
`define CBR_BIT_MEM_WINDOW0_PREFETCHABLE 8
`define CBR_BIT_ROUTE 7
`define CBR_BIT_CARD_RESET 6
`define CBR_BIT_ABORT_MODE 5
`define CBR_BIT_VGA 3
`define CBR_BIT_ISA 2
`define CBR_BIT_SYSERR 1
`define CBR_BIT_PARITY 0

// Function numbers seen on CFG_FUNC
`define CBR_FUNC_CARD 1'b0
`define CBR_FUNC_SERIAL 1'b1

`endif

// ### shared/cbr_fwd_if.sv
`timescale 1ns/100ps
interface cbr_fwd_if;
  import cbr_pkg::*;
  cbr_bridge_t ctl;
  logic serr_en;
  logic card_abort;
  logic card_syserr;
  logic parity_det;
  logic func_irq;
  logic req;
  logic is_io;
  logic [31:0] addr;
  logic target_abort;
  logic serr;
  logic parity_err;
  logic irq_pci;
  logic irq_legacy;
  logic vga_hit;
  logic isa_block;
  modport regs (output ctl, serr_en, card_abort, card_syserr, parity_det,
    func_irq, req, is_io, addr, input target_abort, serr, parity_err,
    irq_pci, irq_legacy, vga_hit, isa_block);
  modport fwd (input ctl, serr_en, card_abort, card_syserr, parity_det,
    func_irq, req, is_io, addr, output target_abort, serr, parity_err,
    irq_pci, irq_legacy, vga_hit, isa_block);
endinterface

// ### shared/cbr_pkg.sv
package cbr_pkg;
  `include "cbr_defines.svh"

  // Bridge control word, bit 15 down to bit 0
  typedef struct packed {
    logic [4:0] reserved_hi;
    logic burst_write_posting_on;
    logic mem_window1_prefetchable;
    logic mem_window0_prefetchable;
    logic card_irq_route_select;
    logic card_reset_ctl;
    logic master_abort_report_mode;
    logic reserved_bits;
    logic vga_forward_on;
    logic isa_alias_filter_on;
    logic card_syserr_forward_on;
    logic card_parity_report_on;
  } cbr_bridge_t;

  // Byte-lane merge of a 16-bit field
  function automatic logic [15:0] cbr_merge16(input logic [15:0] old_v,
      input logic [15:0] new_v, input logic [1:0] be);
    cbr_merge16 = old_v;
    if (be[0]) begin
      cbr_merge16[7:0] = new_v[7:0];
    end
    if (be[1]) begin
      cbr_merge16[15:8] = new_v[15:8];
    end
  endfunction

  // Interrupt pin byte per function; pair tie never changes it
  function automatic logic [7:0] cbr_pin_value(input logic func,
      input logic merge_all);
    if (func == `CBR_FUNC_CARD || merge_all) begin
      cbr_pin_value = `CBR_PIN_FIRST;
    end else begin
      cbr_pin_value = `CBR_PIN_THIRD;
    end
  endfunction
endpackage
